// *** deser_ctrl_pkg.sv ***
// Constants and types for the deserializer port, output and pin control block
// How it works
// - Port select bits steer duplicated registers
// - Read returns selected port, port 1 wins
// - Write updates every selected port
// - Oscillator drives LVDS clocks when input lost, outputs enabled and sleep-select clear
// - Power-up starts lock, lock pin low/Z
// - Lock completes, lock pin driven high when sleep-select set
// - Power-down or output disable sets output states
// - Output enable: valid only active and sleep-select
// - Power-down pin high enables, low powers down
// - Interrupt input active low, driven low powered-down
// - Interrupt low forwarded over back channel
// - Pins forward outputs or back inputs per port
// - Secondary lane forward/back pins only in 2-lane mode
// - 4-bit pin codes: 0x5 forward, 0x3 back
// - Pin levels readable; local output mode allowed
// - 18-bit mode adopted from serializer automatically
package deser_ctrl_pkg;

  // Register offsets
  localparam logic [7:0] GEN_CFG_ADDR = 8'h02;
  localparam logic [7:0] LINK_STATUS_ADDR = 8'h1C;
  localparam logic [7:0] PIN0_CFG_ADDR = 8'h1D;
  localparam logic [7:0] PIN12_CFG_ADDR = 8'h1E;
  localparam logic [7:0] PIN3_CFG_ADDR = 8'h1F;
  localparam logic [7:0] PICK_ADDR = 8'h34;
  localparam logic [7:0] PIN_LEVEL_ADDR = 8'h6E;

  // Field positions
  localparam int OUT_EN_BIT = 7;
  localparam int OSC_EN_BIT = 5;
  localparam int SLEEP_SEL_BIT = 4;
  localparam int FIRST_PICK_BIT = 0;
  localparam int SECOND_PICK_BIT = 1;
  localparam int STAT_LOCK_BIT = 0;
  localparam int STAT_ACTIVE_BIT = 1;
  localparam int STAT_TWO_LANE_BIT = 2;
  localparam int STAT_MODE18_BIT = 3;

  // Values after reset
  localparam logic [7:0] GEN_CFG_RESET = 8'h90;
  localparam logic [1:0] PICK_RESET = 2'h1;
  localparam logic [7:0] PIN_CFG_RESET = 8'h00;

  // Pin function codes
  localparam logic [3:0] CODE_FWD_OUT = 4'h5;
  localparam logic [3:0] CODE_BC_IN = 4'h3;
  localparam logic [3:0] CODE_LOCAL_LOW = 4'h1;
  localparam logic [3:0] CODE_LOCAL_HIGH = 4'h9;

  // Drive state of an output group
  typedef enum logic [1:0] {DRIVE_HIZ, DRIVE_LOW, DRIVE_VALID, DRIVE_OSC} drive_e;

endpackage : deser_ctrl_pkg

// *** deser_port_output_gpio_ctrl.sv ***
// Port-select register bank, output state, interrupt and link pin control
`timescale 1ns/100ps
`default_nettype none

module deser_port_output_gpio_ctrl #(
  parameter int DATA_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Pins and link status (asynchronous)
  input wire logic power_down_pin,
  input wire logic serial_active,
  input wire logic lock_done,
  input wire logic two_lane_mode,
  input wire logic remote_18bit_mode,
  input wire logic local_interrupt_input_n,
  input wire logic [7:0] gpio_fwd_value,
  input wire logic [7:0] gpio_pin_in,
  // Local register access
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Video outputs
  input wire logic [DATA_W-1:0] video_data_in,
  output logic [DATA_W-1:0] video_data_out,
  output logic video_oe_n,
  output logic lvds_clk_en,
  output logic lvds_clk_osc,
  // Lock indicator pin
  output logic lock_out,
  output logic lock_oe_n,
  // Interrupt pin and back channel
  output logic local_interrupt_out,
  output logic local_interrupt_oe_n,
  output logic bc_interrupt,
  // Link pins, lane 1 in bits 7:4
  output logic [7:0] gpio_pin_out,
  output logic [7:0] gpio_pin_oe_n,
  output logic [7:0] bc_gpio_value,
  // Recovery and mode status
  output logic clock_recovery_en,
  output logic color_18bit
);

  localparam int SYNC_W = 22;

  // Nibble of a pin inside the three config bytes of one port
  function automatic logic [3:0] pin_code(input logic [23:0] cfg, input int pin);
    logic [3:0] code;
    code = cfg[3:0];
    case (pin)
      1: code = cfg[11:8];
      2: code = cfg[15:12];
      3: code = cfg[19:16];
      default: code = cfg[3:0];
    endcase
    return code;
  endfunction : pin_code

  // Two-stage synchroniser for every asynchronous input
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {gpio_fwd_value, gpio_pin_in, power_down_pin, serial_active, lock_done,
                    two_lane_mode, remote_18bit_mode, local_interrupt_input_n};
      sync2_reg <= sync1_reg;
    end
  end

  logic [7:0] fwd_s;
  logic [7:0] pin_s;
  logic pwr_on_s;
  logic active_s;
  logic lock_s;
  logic two_lane_s;
  logic mode18_s;
  logic int_n_s;
  logic rst_all;

  assign fwd_s = sync2_reg[21:14];
  assign pin_s = sync2_reg[13:6];
  assign pwr_on_s = sync2_reg[5];
  assign active_s = sync2_reg[4];
  assign lock_s = sync2_reg[3];
  assign two_lane_s = sync2_reg[2];
  assign mode18_s = sync2_reg[1];
  assign int_n_s = sync2_reg[0];
  // Power-down clears all state except the two-stage synchroniser, like a reset
  assign rst_all = reset | ~pwr_on_s;

  // Shared registers
  logic [7:0] gen_cfg_reg;
  logic [1:0] pick_reg;

  always_ff @(posedge clk) begin
    if (rst_all) begin
      gen_cfg_reg <= deser_ctrl_pkg::GEN_CFG_RESET;
    end else if (reg_wr && reg_addr == deser_ctrl_pkg::GEN_CFG_ADDR) begin
      gen_cfg_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst_all) begin
      pick_reg <= deser_ctrl_pkg::PICK_RESET;
    end else if (reg_wr && reg_addr == deser_ctrl_pkg::PICK_ADDR) begin
      pick_reg <= reg_wdata[1:0];
    end
  end

  // Duplicated pin config, three bytes per port
  logic [23:0] cfg_reg [2];

  always_ff @(posedge clk) begin
    for (int p = 0; p < 2; p++) begin
      if (rst_all) begin
        cfg_reg[p] <= {3{deser_ctrl_pkg::PIN_CFG_RESET}};
      end else if (reg_wr && pick_reg[p]) begin
        unique case (reg_addr)
          deser_ctrl_pkg::PIN0_CFG_ADDR: cfg_reg[p][7:0] <= reg_wdata;
          deser_ctrl_pkg::PIN12_CFG_ADDR: cfg_reg[p][15:8] <= reg_wdata;
          deser_ctrl_pkg::PIN3_CFG_ADDR: cfg_reg[p][23:16] <= reg_wdata;
          default: cfg_reg[p] <= cfg_reg[p];
        endcase
      end
    end
  end

  // Read path; port 1 wins when both picks are set
  logic read_port;
  logic any_port;
  logic [7:0] read_mux;
  logic [7:0] status_byte;
  logic lock_now;

  assign lock_now = lock_s & active_s;
  assign read_port = pick_reg[deser_ctrl_pkg::SECOND_PICK_BIT];
  assign any_port = |pick_reg;

  always_comb begin
    status_byte = 8'h00;
    status_byte[deser_ctrl_pkg::STAT_LOCK_BIT] = lock_now;
    status_byte[deser_ctrl_pkg::STAT_ACTIVE_BIT] = active_s;
    status_byte[deser_ctrl_pkg::STAT_TWO_LANE_BIT] = two_lane_s;
    status_byte[deser_ctrl_pkg::STAT_MODE18_BIT] = mode18_s;
  end

  always_comb begin
    read_mux = 8'h00;
    unique case (reg_addr)
      deser_ctrl_pkg::GEN_CFG_ADDR: read_mux = gen_cfg_reg;
      deser_ctrl_pkg::PICK_ADDR: read_mux = {6'h00, pick_reg};
      deser_ctrl_pkg::LINK_STATUS_ADDR: read_mux = status_byte;
      deser_ctrl_pkg::PIN0_CFG_ADDR: read_mux = any_port ? cfg_reg[read_port][7:0] : 8'h00;
      deser_ctrl_pkg::PIN12_CFG_ADDR: read_mux = any_port ? cfg_reg[read_port][15:8] : 8'h00;
      deser_ctrl_pkg::PIN3_CFG_ADDR: read_mux = any_port ? cfg_reg[read_port][23:16] : 8'h00;
      deser_ctrl_pkg::PIN_LEVEL_ADDR: begin
        if (any_port) begin
          read_mux = {4'h0, read_port ? pin_s[7:4] : pin_s[3:0]};
        end
      end
      default: read_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst_all) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= read_mux;
      end
    end
  end

  // Output state selection
  deser_ctrl_pkg::drive_e data_mode;
  deser_ctrl_pkg::drive_e lvds_mode;
  logic lock_drive;
  logic lock_hiz;
  logic out_en;
  logic sleep_sel;

  assign out_en = gen_cfg_reg[deser_ctrl_pkg::OUT_EN_BIT];
  assign sleep_sel = gen_cfg_reg[deser_ctrl_pkg::SLEEP_SEL_BIT];

  always_comb begin
    lock_hiz = 1'b0;
    lock_drive = 1'b0;
    data_mode = deser_ctrl_pkg::DRIVE_LOW;
    lvds_mode = deser_ctrl_pkg::DRIVE_LOW;
    if (!out_en) begin
      if (sleep_sel) begin
        lock_drive = lock_now;
        data_mode = deser_ctrl_pkg::DRIVE_HIZ;
        lvds_mode = deser_ctrl_pkg::DRIVE_HIZ;
      end
    end else if (!active_s) begin
      if (!sleep_sel && gen_cfg_reg[deser_ctrl_pkg::OSC_EN_BIT]) begin
        lvds_mode = deser_ctrl_pkg::DRIVE_OSC;
      end
    end else if (sleep_sel) begin
      lock_drive = lock_now;
      data_mode = deser_ctrl_pkg::DRIVE_VALID;
      lvds_mode = deser_ctrl_pkg::DRIVE_VALID;
    end
  end

  // Registered output groups; power-down leaves lock and video outputs floating
  always_ff @(posedge clk) begin
    if (rst_all) begin
      lock_out <= 1'b0;
      lock_oe_n <= 1'b1;
      clock_recovery_en <= 1'b0;
    end else begin
      lock_out <= lock_drive;
      lock_oe_n <= lock_hiz;
      clock_recovery_en <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst_all) begin
      video_data_out <= '0;
      video_oe_n <= 1'b1;
      lvds_clk_en <= 1'b0;
      lvds_clk_osc <= 1'b0;
    end else begin
      video_data_out <= (lvds_mode == deser_ctrl_pkg::DRIVE_VALID) ? video_data_in : '0;
      video_oe_n <= (lvds_mode == deser_ctrl_pkg::DRIVE_HIZ);
      lvds_clk_en <= (lvds_mode == deser_ctrl_pkg::DRIVE_VALID);
      lvds_clk_osc <= (lvds_mode == deser_ctrl_pkg::DRIVE_OSC);
    end
  end

  // Interrupt: pin pulled low while powered down, level sent upstream
  always_ff @(posedge clk) begin
    local_interrupt_out <= 1'b0;
    if (rst_all) begin
      // Plain reset floats the pin; only power-down pulls it low
      local_interrupt_oe_n <= reset;
      bc_interrupt <= 1'b0;
    end else begin
      local_interrupt_oe_n <= 1'b1;
      bc_interrupt <= ~int_n_s;
    end
  end

  // Link pins, lane index k/4, pin index k%4
  for (genvar k = 0; k < 8; k++) begin : g_pin
    logic [3:0] code;
    logic lane_ok;
    logic fwd;
    logic local_out;

    assign code = pin_code(cfg_reg[k / 4], k % 4);
    assign lane_ok = (k < 4) || two_lane_s;
    assign fwd = lane_ok && code == deser_ctrl_pkg::CODE_FWD_OUT;
    assign local_out = code == deser_ctrl_pkg::CODE_LOCAL_LOW || code == deser_ctrl_pkg::CODE_LOCAL_HIGH;

    always_ff @(posedge clk) begin
      if (rst_all) begin
        gpio_pin_out[k] <= 1'b0;
        gpio_pin_oe_n[k] <= 1'b1;
        bc_gpio_value[k] <= 1'b0;
      end else begin
        bc_gpio_value[k] <= lane_ok && code == deser_ctrl_pkg::CODE_BC_IN && pin_s[k];
        if (data_mode == deser_ctrl_pkg::DRIVE_HIZ || !(fwd || local_out)) begin
          gpio_pin_oe_n[k] <= 1'b1;
          gpio_pin_out[k] <= 1'b0;
        end else begin
          gpio_pin_oe_n[k] <= 1'b0;
          if (data_mode == deser_ctrl_pkg::DRIVE_VALID) begin
            gpio_pin_out[k] <= fwd ? fwd_s[k] : (code == deser_ctrl_pkg::CODE_LOCAL_HIGH);
          end else begin
            gpio_pin_out[k] <= 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst_all) begin
      color_18bit <= 1'b0;
    end else begin
      color_18bit <= mode18_s;
    end
  end

endmodule : deser_port_output_gpio_ctrl

`default_nettype wire

// *** deser_ctrl_asserts.sv ***
// Checker for the port, output and pin control block
`timescale 1ns/100ps
`default_nettype none
module deser_ctrl_asserts #(
  parameter int DATA_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Watched ports
  input wire logic power_down_pin,
  input wire logic lock_done,
  input wire logic serial_active,
  input wire logic local_interrupt_input_n,
  input wire logic reg_rd,
  input wire logic reg_rvalid,
  input wire logic [DATA_W-1:0] video_data_out,
  input wire logic video_oe_n,
  input wire logic lvds_clk_en,
  input wire logic lvds_clk_osc,
  input wire logic lock_out,
  input wire logic lock_oe_n,
  input wire logic bc_interrupt,
  input wire logic [7:0] gpio_pin_oe_n,
  input wire logic clock_recovery_en
);
  // Own copy of the pin synchroniser, one stage longer for slack
  logic [2:0] pd_sync;
  wire logic live;
  assign live = &pd_sync[2:1];
  always_ff @(posedge clk) begin
    pd_sync <= reset ? 3'h0 : {pd_sync[1:0], power_down_pin};
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence irq_held;
    (live && !local_interrupt_input_n) [*4];
  endsequence
  sequence irq_idle;
    (live && local_interrupt_input_n) [*4];
  endsequence
  chk_read_answer: assert property (live && reg_rd |=> reg_rvalid)
    else $error("read request not answered");
  chk_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read answer without request");
  chk_pd_hiz: assert property (!pd_sync[1] |=> video_oe_n && lock_oe_n && &gpio_pin_oe_n && !clock_recovery_en)
    else $error("outputs driven while powered down");
  chk_irq_fwd: assert property (irq_held |=> bc_interrupt)
    else $error("interrupt not forwarded");
  chk_irq_quiet: assert property (irq_idle |=> !bc_interrupt)
    else $error("interrupt forwarded while input high");
  chk_unlocked_low: assert property ((live && !lock_done) [*4] |=> !lock_out)
    else $error("lock high before lock");
  chk_static_data: assert property (!serial_active [*4] |=> video_data_out == '0)
    else $error("data driven on static input");
  chk_osc_excl: assert property (!(lvds_clk_en && lvds_clk_osc))
    else $error("oscillator and recovered clock together");
  chk_clk_drive: assert property (lvds_clk_en |-> !video_oe_n)
    else $error("clock valid while outputs floating");
  chk_lock_driven: assert property (live [*2] |=> !lock_oe_n)
    else $error("lock pin floating while powered");
endmodule : deser_ctrl_asserts
bind deser_port_output_gpio_ctrl deser_ctrl_asserts #(.DATA_W(DATA_W)) chk_u (.clk, .reset, .power_down_pin,
  .lock_done, .serial_active, .local_interrupt_input_n, .reg_rd, .reg_rvalid, .video_data_out, .video_oe_n,
  .lvds_clk_en, .lvds_clk_osc, .lock_out, .lock_oe_n, .bc_interrupt, .gpio_pin_oe_n, .clock_recovery_en);
`default_nettype wire

// *** ser_partner.sv ***
// Behavioural model of the paired serializer across the link
`timescale 1ns/100ps
`default_nettype none
module ser_partner (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Serializer configuration and host side
  input wire logic irq_en,
  input wire logic status_rd,
  input wire logic mode18_cfg,
  input wire logic [7:0] ser_bc_sel,
  input wire logic [7:0] ser_pins,
  output logic remote_interrupt_output_n,
  output logic [7:0] ser_seen,
  // Link side
  input wire logic bc_interrupt,
  input wire logic [7:0] bc_gpio_value,
  output logic [7:0] gpio_fwd_value,
  output logic remote_18bit_mode
);
  logic irq_prev_reg;
  always_ff @(posedge clk) begin
    irq_prev_reg <= bc_interrupt;
    if (reset || status_rd) begin
      remote_interrupt_output_n <= 1'h1;
    end else if (irq_en && bc_interrupt && !irq_prev_reg) begin
      remote_interrupt_output_n <= 1'h0;
    end
  end
  // Slots not sent forward toggle, so a stale level never passes as valid
  always_ff @(posedge clk) begin
    gpio_fwd_value <= reset ? 8'h00 : (ser_bc_sel & ~gpio_fwd_value) | (~ser_bc_sel & ser_pins);
    ser_seen <= ser_bc_sel & bc_gpio_value;
    remote_18bit_mode <= mode18_cfg;
  end
endmodule : ser_partner
`default_nettype wire

// *** deser_port_output_gpio_ctrl_tb_top.sv ***
// Testbench for the port, output and pin control block
`timescale 1ns/100ps
`default_nettype none
module deser_port_output_gpio_ctrl_tb_top;
  logic clk, reset, power_down_pin, serial_active, lock_done, two_lane_mode, local_interrupt_input_n;
  logic reg_wr, reg_rd, reg_rvalid, video_oe_n, lvds_clk_en, lvds_clk_osc, lock_out, lock_oe_n;
  logic local_interrupt_out, local_interrupt_oe_n, bc_interrupt, clock_recovery_en, color_18bit;
  logic irq_en, status_rd, mode18_cfg, remote_interrupt_output_n, remote_18bit_mode;
  logic [7:0] gpio_fwd_value, gpio_pin_in, reg_addr, reg_wdata, reg_rdata, video_data_in, video_data_out;
  logic [7:0] gpio_pin_out, gpio_pin_oe_n, bc_gpio_value, ser_pins, ser_seen, ser_bc_sel, rd_val;
  int miscompares = 0;
  int checked = 0;
  typedef struct packed {logic wr; logic [7:0] a; logic [7:0] d;} row_s;
  typedef struct packed {logic [7:0] cfg; logic act; logic [3:0] exp;} ost_s;
  row_s rows[17] = '{'{1'h0, 8'h02, 8'h90}, '{1'h0, 8'h34, 8'h01}, '{1'h0, 8'h1D, 8'h00},
    '{1'h1, 8'h34, 8'h03}, '{1'h1, 8'h1D, 8'h05}, '{1'h1, 8'h34, 8'h01}, '{1'h1, 8'h1D, 8'h03},
    '{1'h0, 8'h1D, 8'h03}, '{1'h1, 8'h34, 8'h02}, '{1'h0, 8'h1D, 8'h05}, '{1'h1, 8'h34, 8'h03},
    '{1'h0, 8'h1D, 8'h05}, '{1'h1, 8'h34, 8'h00}, '{1'h0, 8'h1E, 8'h00}, '{1'h1, 8'h5A, 8'hA5},
    '{1'h0, 8'h5A, 8'h00}, '{1'h1, 8'h34, 8'h01}};
  // Expected {lock, video floating, oscillator, recovered clock}
  ost_s ost[6] = '{'{8'h00, 1'h1, 4'h0}, '{8'h10, 1'h1, 4'hC}, '{8'h80, 1'h1, 4'h0},
    '{8'h90, 1'h1, 4'h9}, '{8'hA0, 1'h0, 4'h2}, '{8'h90, 1'h0, 4'h0}};
  deser_port_output_gpio_ctrl #(.DATA_W(8)) dut_u (.clk, .reset, .power_down_pin, .serial_active, .lock_done,
    .two_lane_mode, .remote_18bit_mode, .local_interrupt_input_n, .gpio_fwd_value, .gpio_pin_in, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid, .video_data_in, .video_data_out, .video_oe_n,
    .lvds_clk_en, .lvds_clk_osc, .lock_out, .lock_oe_n, .local_interrupt_out, .local_interrupt_oe_n,
    .bc_interrupt, .gpio_pin_out, .gpio_pin_oe_n, .bc_gpio_value, .clock_recovery_en, .color_18bit);
  ser_partner ser_u (.clk, .reset, .irq_en, .status_rd, .mode18_cfg, .ser_bc_sel, .ser_pins,
    .remote_interrupt_output_n, .ser_seen, .bc_interrupt, .bc_gpio_value, .gpio_fwd_value, .remote_18bit_mode);
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected at %0t: saw %h expected %h", $time, s, e);
    end
  endtask : chk
  // Leaves every caller just after a rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'h1;
    cyc(1);
    reg_wr = 1'h0;
    cyc(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    n = 0;
    reg_addr = a;
    reg_rd = 1'h1;
    cyc(1);
    reg_rd = 1'h0;
    while (reg_rvalid !== 1'h1 && n < 8) begin
      cyc(1);
      n++;
    end
    if (n == 8) begin
      miscompares++;
      summarize();
    end
    d = reg_rdata;
    cyc(1);
  endtask : rd
  task automatic wait_irq(input logic lvl);
    int n;
    n = 0;
    while (remote_interrupt_output_n !== lvl && n < 12) begin
      cyc(1);
      n++;
    end
    chk({7'h0, remote_interrupt_output_n}, {7'h0, lvl});
    if (n == 12) summarize();
  endtask : wait_irq
  initial begin
    {reset, power_down_pin, serial_active, lock_done, local_interrupt_input_n} = 5'h1F;
    {two_lane_mode, reg_wr, reg_rd, irq_en, status_rd, mode18_cfg} = 6'h0;
    {gpio_pin_in, reg_addr, reg_wdata, ser_pins, ser_bc_sel} = 40'h0;
    video_data_in = 8'h3C;
    cyc(5);
    reset = 1'h0;
    cyc(4);
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        wr(rows[i].a, rows[i].d);
      end else begin
        rd(rows[i].a, rd_val);
        chk(rd_val, rows[i].d);
      end
    end
    foreach (ost[i]) begin
      serial_active = ost[i].act;
      wr(8'h02, ost[i].cfg);
      cyc(4);
      chk({4'h0, lock_out, video_oe_n, lvds_clk_osc, lvds_clk_en}, {4'h0, ost[i].exp});
      chk(video_data_out, (ost[i].cfg == 8'h90 && ost[i].act) ? 8'h3C : 8'h00);
      chk({7'h0, lock_oe_n}, 8'h00);
    end
    serial_active = 1'h1;
    ser_pins = 8'h01;
    ser_bc_sel = 8'h02;
    wr(8'h1D, 8'h05);
    wr(8'h1E, 8'h93);
    wr(8'h1F, 8'h01);
    gpio_pin_in = 8'h02;
    cyc(5);
    chk(gpio_pin_oe_n, 8'hF2);
    chk(gpio_pin_out & 8'h0D, 8'h05);
    chk(ser_seen, 8'h02);
    rd(8'h6E, rd_val);
    chk(rd_val & 8'h0F, 8'h02);
    wr(8'h34, 8'h02);
    wr(8'h1D, 8'h05);
    ser_pins = 8'h11;
    cyc(5);
    chk({6'h0, gpio_pin_oe_n[4], gpio_pin_oe_n[0]}, 8'h02);
    two_lane_mode = 1'h1;
    mode18_cfg = 1'h1;
    cyc(6);
    chk({5'h0, gpio_pin_oe_n[4], gpio_pin_out[4], gpio_pin_oe_n[0]}, 8'h02);
    chk({7'h0, color_18bit}, 8'h01);
    irq_en = 1'h1;
    local_interrupt_input_n = 1'h0;
    wait_irq(1'h0);
    status_rd = 1'h1;
    cyc(1);
    status_rd = 1'h0;
    cyc(1);
    chk({7'h0, remote_interrupt_output_n}, 8'h01);
    local_interrupt_input_n = 1'h1;
    cyc(5);
    local_interrupt_input_n = 1'h0;
    wait_irq(1'h0);
    local_interrupt_input_n = 1'h1;
    power_down_pin = 1'h0;
    lock_done = 1'h0;
    cyc(4);
    chk({4'h0, video_oe_n, lock_oe_n, local_interrupt_oe_n, clock_recovery_en}, 8'h0C);
    chk(gpio_pin_oe_n, 8'hFF);
    chk({7'h0, local_interrupt_out}, 8'h00);
    power_down_pin = 1'h1;
    cyc(6);
    chk({6'h0, clock_recovery_en, lock_out}, 8'h02);
    rd(8'h34, rd_val);
    chk(rd_val, 8'h01);
    rd(8'h1C, rd_val);
    chk(rd_val, 8'h0E);
    summarize();
  end
endmodule : deser_port_output_gpio_ctrl_tb_top
`default_nettype wire
